// ---- hdl/vtp_defs.svh ----
// register offsets, field positions, reset values and indirect map of the test-pattern block
`ifndef VTP_DEFS_SVH
`define VTP_DEFS_SVH
// register indices, byte address is four times the index
`define VTP_IDX_CTL 10'h064
`define VTP_IDX_CFG 10'h065
`define VTP_IDX_IA 10'h066
`define VTP_IDX_ID 10'h067
`define VTP_IDX_PSEL 10'h070
`define VTP_IDX_STAT 10'h071
// control register fields
`define VTP_CTL_EN 0
`define VTP_CTL_SEL_LSB 4
`define VTP_CTL_RST 8'h10
// configuration register fields
`define VTP_CFG_SCALE 6
`define VTP_CFG_CUST 5
`define VTP_CFG_B18 4
`define VTP_CFG_EXTCLK 3
`define VTP_CFG_TSEL 2
`define VTP_CFG_INV 1
`define VTP_CFG_ASCRL 0
`define VTP_CFG_RST 8'h00
`define VTP_IA_RST 8'h00
// indirect map
`define VTP_IND_DEPTH 32
`define VTP_IND_THL 5'h00
`define VTP_IND_THH 5'h01
`define VTP_IND_TVL 5'h02
`define VTP_IND_TVH 5'h03
`define VTP_IND_AHL 5'h04
`define VTP_IND_AHH 5'h05
`define VTP_IND_AVL 5'h06
`define VTP_IND_AVH 5'h07
`define VTP_IND_HSW 5'h08
`define VTP_IND_VSW 5'h09
`define VTP_IND_HBP 5'h0A
`define VTP_IND_VBP 5'h0B
`define VTP_IND_SCFG 5'h0C
`define VTP_IND_FT 5'h0D
`define VTP_IND_CR 5'h0E
`define VTP_IND_CG 5'h0F
`define VTP_IND_CB 5'h10
`define VTP_IND_DIV 5'h11
// pixel formats and colours
`define VTP_LVL_SH18 6
`define VTP_LVL_SH24 8
`define VTP_MASK18 24'hFC_FCFC
`define VTP_WHITE 24'hFF_FFFF
`define VTP_BLACK 24'h00_0000
`endif

// ---- hdl/vtp_pkg.sv ----
// shared types of the test-pattern block
`default_nettype none
package vtp_pkg;
	typedef enum logic [3:0] {
		PAT_CHECKER = 4'b0000, PAT_WHITE = 4'b0001, PAT_BLACK = 4'b0010, PAT_RED = 4'b0011,
		PAT_GREEN = 4'b0100, PAT_BLUE = 4'b0101, PAT_HG_W = 4'b0110, PAT_HG_R = 4'b0111,
		PAT_HG_G = 4'b1000, PAT_HG_B = 4'b1001, PAT_VG_W = 4'b1010, PAT_VG_R = 4'b1011,
		PAT_VG_G = 4'b1100, PAT_VG_B = 4'b1101, PAT_CUSTOM = 4'b1110, PAT_ALT_PIX = 4'b1111
	} vtp_pattern_e;
	typedef logic [11:0] vtp_coord_t;
endpackage
`default_nettype wire

// ---- hdl/vtp_top.sv ----
// test-pattern generator: apb registers, per-port timing and colour, output fifos
// Operation
// - checker scale bit draws checker squares 8x8 and alternating-pixel columns 8 wide, else 1 pixel.
// - custom-checker bit alternates custom colour with black, else white with black.
// - 18-bit select gives 64 gradient levels, otherwise 256 levels.
// - in 18-bit mode only six top bits per colour carry data.
// - internal timing clocks from external pixel clock if source bit set, else divider.
// - clock source is ignored while timing select is zero.
// - timing select one builds timing from programmed sizes, syncs and porches.
// - timing select zero follows incoming pixel clock, enable and syncs.
// - invert bit outputs the bitwise inverse of the pattern colour.
// - auto-scroll steps to next pattern after programmed frame count.
// - without auto-scroll the selected pattern stays.
// - every configuration field acts only on the port selected for access.
// - eight-bit indirect address register picks indirect location, resets zero.
// - indirect data write stores, read returns the addressed location.
// - checker code 0000, alternating-pixel code 1111.
// - patterns come out only while the enable bit is one.
`include "vtp_defs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module vtp_fifo #(
	parameter int W = 27,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("vtp_fifo depth must be a power of two");
	end

	assign in_ready = (cnt_reg != (AW + 1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];

	// storage has no reset, only the pointers matter
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_reg] <= in_data;
	end

	// pointer and fill count update
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module vtp_top #(
	parameter int PORTS = 2,
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// external video timing, asynchronous pins
	input wire logic VID_PCLK,
	input wire logic VID_DE,
	input wire logic VID_HS,
	input wire logic VID_VS,
	// pattern stream per port toward the serial link
	output logic [PORTS-1:0] PIX_VALID,
	input wire logic [PORTS-1:0] PIX_READY,
	output logic [PORTS*24-1:0] PIX_RGB,
	output logic [PORTS-1:0] PIX_DE,
	output logic [PORTS-1:0] PIX_HS,
	output logic [PORTS-1:0] PIX_VS
);
	localparam int FW = 27;

	if (PORTS != 2) begin : g_chk
		$error("vtp_top supports exactly two ports");
	end

	// colour of one pixel for a pattern code
	function automatic logic [23:0] pat_colour(input logic [3:0] sel, input vtp_pkg::vtp_coord_t x,
			input vtp_pkg::vtp_coord_t y, input logic [7:0] cfg, input logic [23:0] crgb,
			input vtp_pkg::vtp_coord_t ah, input vtp_pkg::vtp_coord_t av);
		logic cx, cy, chk;
		logic [19:0] hn, vn;
		logic [7:0] hg, vg;
		logic [23:0] c;
		cx = cfg[`VTP_CFG_SCALE] ? x[3] : x[0];
		cy = cfg[`VTP_CFG_SCALE] ? y[3] : y[0];
		chk = cx ^ cy;
		// gradient level = position * levels / active size
		hn = cfg[`VTP_CFG_B18] ? ({8'h00, x} << `VTP_LVL_SH18) : ({8'h00, x} << `VTP_LVL_SH24);
		vn = cfg[`VTP_CFG_B18] ? ({8'h00, y} << `VTP_LVL_SH18) : ({8'h00, y} << `VTP_LVL_SH24);
		hg = (ah == '0) ? 8'h00 : 8'(hn / {8'h00, ah});
		vg = (av == '0) ? 8'h00 : 8'(vn / {8'h00, av});
		if (cfg[`VTP_CFG_B18]) begin
			hg = {hg[5:0], 2'b00};
			vg = {vg[5:0], 2'b00};
		end
		unique case (vtp_pkg::vtp_pattern_e'(sel))
			vtp_pkg::PAT_CHECKER: c = chk ? (cfg[`VTP_CFG_CUST] ? crgb : `VTP_WHITE) : `VTP_BLACK;
			vtp_pkg::PAT_WHITE: c = `VTP_WHITE;
			vtp_pkg::PAT_BLACK: c = `VTP_BLACK;
			vtp_pkg::PAT_RED: c = 24'hFF_0000;
			vtp_pkg::PAT_GREEN: c = 24'h00_FF00;
			vtp_pkg::PAT_BLUE: c = 24'h00_00FF;
			vtp_pkg::PAT_HG_W: c = {hg, hg, hg};
			vtp_pkg::PAT_HG_R: c = {hg, 16'h0000};
			vtp_pkg::PAT_HG_G: c = {8'h00, hg, 8'h00};
			vtp_pkg::PAT_HG_B: c = {16'h0000, hg};
			vtp_pkg::PAT_VG_W: c = {vg, vg, vg};
			vtp_pkg::PAT_VG_R: c = {vg, 16'h0000};
			vtp_pkg::PAT_VG_G: c = {8'h00, vg, 8'h00};
			vtp_pkg::PAT_VG_B: c = {16'h0000, vg};
			vtp_pkg::PAT_CUSTOM: c = crgb;
			vtp_pkg::PAT_ALT_PIX: c = cx ? `VTP_WHITE : `VTP_BLACK;
		endcase
		if (cfg[`VTP_CFG_INV])
			c = ~c;
		if (cfg[`VTP_CFG_B18])
			c = c & `VTP_MASK18;
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// register file, one copy per port except port select and read data
	logic [7:0] ctl_reg [PORTS];
	logic [7:0] cfg_reg [PORTS];
	logic [7:0] ia_reg [PORTS];
	logic [7:0] ind_mem [PORTS][`VTP_IND_DEPTH];
	logic port_sel_reg;
	logic [PORTS-1:0] ovf_reg;
	logic [3:0] cur_pat [PORTS];
	logic [31:0] prdata_reg;

	// apb decode
	wire [9:0] idx = PADDR[11:2];
	wire hit_ctl = (idx == `VTP_IDX_CTL);
	wire hit_cfg = (idx == `VTP_IDX_CFG);
	wire hit_ia = (idx == `VTP_IDX_IA);
	wire hit_id = (idx == `VTP_IDX_ID);
	wire hit_psel = (idx == `VTP_IDX_PSEL);
	wire hit_stat = (idx == `VTP_IDX_STAT);
	wire mapped = hit_ctl | hit_cfg | hit_ia | hit_id | hit_psel | hit_stat;
	wire setup = PSEL && !PENABLE;
	wire wr_en = PSEL && PENABLE && PWRITE && mapped && PSTRB[0];
	wire [7:0] wb = PWDATA[7:0];
	wire ps = port_sel_reg;
	wire ia_ok = (ia_reg[ps] < 8'(`VTP_IND_DEPTH));
	wire [4:0] ia_lo = ia_reg[ps][4:0];
	// indirect read returns the addressed location, zero past the end
	wire [7:0] id_rd = ia_ok ? ind_mem[ps][ia_lo] : 8'h00;
	wire [7:0] rd_mux = hit_ctl ? ctl_reg[ps] :
		hit_cfg ? cfg_reg[ps] :
		hit_ia ? ia_reg[ps] :
		hit_id ? id_rd :
		hit_psel ? {7'h00, port_sel_reg} :
		hit_stat ? {cur_pat[ps], 2'b00, ovf_reg} : 8'h00;

	// zero wait states: read data is captured during setup
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA = prdata_reg;

	// read data capture
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			prdata_reg <= 32'h0000_0000;
		else if (setup && !PWRITE)
			prdata_reg <= {24'h00_0000, rd_mux};
	end

	// port select register
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			port_sel_reg <= 1'b0;
		else if (wr_en && hit_psel)
			port_sel_reg <= wb[0];
	end

	// writes land only on the port picked for access
	for (genvar p = 0; p < PORTS; p++) begin : g_regs
		wire sel_me = (ps == 1'(p));
		always_ff @(posedge SYS_CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				ctl_reg[p] <= `VTP_CTL_RST;
				cfg_reg[p] <= `VTP_CFG_RST;
				ia_reg[p] <= `VTP_IA_RST;
			end else if (wr_en && sel_me) begin
				if (hit_ctl)
					ctl_reg[p] <= wb & 8'hF5;
				if (hit_cfg)
					cfg_reg[p] <= wb;
				if (hit_ia)
					ia_reg[p] <= wb;
			end
		end
		// indirect store, written through the data register
		always_ff @(posedge SYS_CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				for (int i = 0; i < `VTP_IND_DEPTH; i++)
					ind_mem[p][i] <= 8'h00;
			end else if (wr_en && sel_me && hit_id && ia_ok) begin
				ind_mem[p][ia_lo] <= wb;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// external pin synchronisers, shared by both ports
	logic [3:0] pin_ff1, pin_ff2, pin_ff3;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pin_ff1 <= 4'h0;
			pin_ff2 <= 4'h0;
			pin_ff3 <= 4'h0;
		end else begin
			pin_ff1 <= {VID_PCLK, VID_DE, VID_HS, VID_VS};
			pin_ff2 <= pin_ff1;
			pin_ff3 <= pin_ff2;
		end
	end
	// the pixel clock is oversampled, so it must run well below sys_clk / 2
	wire pclk_rise = pin_ff2[3] && !pin_ff3[3];
	wire ext_de = pin_ff3[2];
	wire ext_hs = pin_ff3[1];
	wire ext_vs = pin_ff3[0];

	////////////////////////////////////////////////////////////////////////////
	// one generator per port
	for (genvar p = 0; p < PORTS; p++) begin : g_gen
		wire [7:0] cfg = cfg_reg[p];
		wire en = ctl_reg[p][`VTP_CTL_EN];
		wire tsel = cfg[`VTP_CFG_TSEL];
		wire [11:0] tot_h = {ind_mem[p][`VTP_IND_THH][3:0], ind_mem[p][`VTP_IND_THL]};
		wire [11:0] tot_v = {ind_mem[p][`VTP_IND_TVH][3:0], ind_mem[p][`VTP_IND_TVL]};
		wire [11:0] act_h = {ind_mem[p][`VTP_IND_AHH][3:0], ind_mem[p][`VTP_IND_AHL]};
		wire [11:0] act_v = {ind_mem[p][`VTP_IND_AVH][3:0], ind_mem[p][`VTP_IND_AVL]};
		wire [11:0] h_start = 12'(ind_mem[p][`VTP_IND_HSW]) + 12'(ind_mem[p][`VTP_IND_HBP]);
		wire [11:0] v_start = 12'(ind_mem[p][`VTP_IND_VSW]) + 12'(ind_mem[p][`VTP_IND_VBP]);
		wire [23:0] crgb = {ind_mem[p][`VTP_IND_CR], ind_mem[p][`VTP_IND_CG], ind_mem[p][`VTP_IND_CB]};
		wire [7:0] ftime = ind_mem[p][`VTP_IND_FT];
		logic [7:0] div_reg;
		logic [11:0] h_reg, v_reg, ex_reg, ey_reg;
		logic [7:0] frm_reg;
		logic [3:0] scr_reg;
		logic ede_reg, evs_reg;
		logic fifo_rdy;
		logic [FW-1:0] fifo_q;

		// internal divided clock
		wire div_tick = (div_reg >= ind_mem[p][`VTP_IND_DIV]);
		// source bit only matters under internal timing
		wire tick = tsel ? (cfg[`VTP_CFG_EXTCLK] ? pclk_rise : div_tick) : pclk_rise;
		// internal timing stalls on a full fifo, external timing cannot
		wire step = tick && en && (fifo_rdy || !tsel);
		wire h_last = (h_reg >= tot_h - 12'h001);
		wire v_last = (v_reg >= tot_v - 12'h001);
		wire i_hs = (h_reg < 12'(ind_mem[p][`VTP_IND_HSW])) ^ ind_mem[p][`VTP_IND_SCFG][0];
		wire i_vs = (v_reg < 12'(ind_mem[p][`VTP_IND_VSW])) ^ ind_mem[p][`VTP_IND_SCFG][1];
		wire i_de = (h_reg >= h_start) && (h_reg < h_start + act_h) && (v_reg >= v_start) && (v_reg < v_start + act_v);
		// timing source choice
		wire o_de = tsel ? i_de : ext_de;
		wire o_hs = tsel ? i_hs : ext_hs;
		wire o_vs = tsel ? i_vs : ext_vs;
		wire [11:0] px = tsel ? h_reg - h_start : ex_reg;
		wire [11:0] py = tsel ? v_reg - v_start : ey_reg;
		wire frame_end = tsel ? (step && h_last && v_last) : (step && ext_vs && !evs_reg);
		wire frame_due = (frm_reg + 8'h01 >= ftime);
		wire [3:0] pat = cfg[`VTP_CFG_ASCRL] ? scr_reg : ctl_reg[p][7:`VTP_CTL_SEL_LSB];
		wire [23:0] rgb = o_de ? pat_colour(pat, px, py, cfg, crgb, act_h, act_v) : `VTP_BLACK;

		assign cur_pat[p] = pat;

		// divider runs always so its phase is free of register timing
		always_ff @(posedge SYS_CLK or negedge ARST_N) begin
			if (!ARST_N)
				div_reg <= 8'h00;
			else
				div_reg <= div_tick ? 8'h00 : div_reg + 8'h01;
		end

		// internal raster counters
		always_ff @(posedge SYS_CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				h_reg <= 12'h000;
				v_reg <= 12'h000;
			end else if (!en || !tsel) begin
				h_reg <= 12'h000;
				v_reg <= 12'h000;
			end else if (step) begin
				h_reg <= h_last ? 12'h000 : h_reg + 12'h001;
				if (h_last)
					v_reg <= v_last ? 12'h000 : v_reg + 12'h001;
			end
		end

		// position recovered from external timing
		always_ff @(posedge SYS_CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				ex_reg <= 12'h000;
				ey_reg <= 12'h000;
				ede_reg <= 1'b0;
				evs_reg <= 1'b0;
			end else if (tick) begin
				ede_reg <= ext_de;
				evs_reg <= ext_vs;
				ex_reg <= ext_de ? ex_reg + 12'h001 : 12'h000;
				if (ext_vs)
					ey_reg <= 12'h000;
				else if (ede_reg && !ext_de)
					ey_reg <= ey_reg + 12'h001;
			end
		end

		// auto-scroll frame counter and pattern stepper
		always_ff @(posedge SYS_CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				frm_reg <= 8'h00;
				scr_reg <= 4'h0;
			end else if (!cfg[`VTP_CFG_ASCRL]) begin
				frm_reg <= 8'h00;
				scr_reg <= ctl_reg[p][7:`VTP_CTL_SEL_LSB];
			end else if (frame_end) begin
				frm_reg <= frame_due ? 8'h00 : frm_reg + 8'h01;
				if (frame_due)
					scr_reg <= scr_reg + 4'h1;
			end
		end

		// overflow when external timing meets a full fifo; set wins over clear
		wire ovf_set = tick && en && !tsel && !fifo_rdy;
		wire ovf_clr = wr_en && hit_stat && wb[p];
		always_ff @(posedge SYS_CLK or negedge ARST_N) begin
			if (!ARST_N)
				ovf_reg[p] <= 1'b0;
			else
				ovf_reg[p] <= ovf_set || (ovf_reg[p] && !ovf_clr);
		end

		vtp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
			.clk(SYS_CLK),
			.arst_n(ARST_N),
			.in_valid(step),
			.in_ready(fifo_rdy),
			.in_data({o_vs, o_hs, o_de, rgb}),
			.out_valid(PIX_VALID[p]),
			.out_ready(PIX_READY[p]),
			.out_data(fifo_q)
		);

		assign PIX_RGB[p*24 +: 24] = fifo_q[23:0];
		assign PIX_DE[p] = fifo_q[24];
		assign PIX_HS[p] = fifo_q[25];
		assign PIX_VS[p] = fifo_q[26];
	end
endmodule
`default_nettype wire

// ---- verif/vtp_monitor.sv ----
// assertion checker on the apb side and pixel streams of the test-pattern block
`include "vtp_defs.svh"
`default_nettype none
module vtp_monitor #(
	parameter int PORTS = 2
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// pixel streams
	input wire logic [PORTS-1:0] PIX_VALID,
	input wire logic [PORTS-1:0] PIX_READY,
	input wire logic [PORTS*24-1:0] PIX_RGB,
	input wire logic [PORTS-1:0] PIX_DE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	// decode of the mapped word indices, low address bits ignored
	wire logic [9:0] idx = PADDR[11:2];
	wire logic mapped = idx inside {`VTP_IDX_CTL, `VTP_IDX_CFG, `VTP_IDX_IA, `VTP_IDX_ID, `VTP_IDX_PSEL, `VTP_IDX_STAT};
	////////////////////////////////////////////////////////////////////////////////
	property p_ready;
		PSEL && PENABLE |-> PREADY;
	endproperty
	a_ready: assert property (p_ready) else $error("access phase without ready");
	property p_err_map;
		PSEL && PENABLE |-> PSLVERR == !mapped;
	endproperty
	a_err_map: assert property (p_err_map) else $error("error flag disagrees with map");
	property p_err_phase;
		PSLVERR |-> PSEL && PENABLE;
	endproperty
	a_err_phase: assert property (p_err_phase) else $error("error flag outside access");
	property p_rd_high;
		PRDATA[31:8] == 24'h00_0000;
	endproperty
	a_rd_high: assert property (p_rd_high) else $error("upper read bits not zero");
	property p_rd_hold;
		!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without setup");
	property p_unmapped_rd;
		PSEL && !PENABLE && !PWRITE && !mapped |=> PRDATA == 32'h0000_0000;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
	property p_hold0;
		PIX_VALID[0] && !PIX_READY[0] |=> PIX_VALID[0] && $stable(PIX_RGB[23:0]) && $stable(PIX_DE[0]);
	endproperty
	a_hold0: assert property (p_hold0) else $error("port 0 word changed while stalled");
	property p_hold1;
		PIX_VALID[1] && !PIX_READY[1] |=> PIX_VALID[1] && $stable(PIX_RGB[47:24]);
	endproperty
	a_hold1: assert property (p_hold1) else $error("port 1 word changed while stalled");
	property p_blank;
		PIX_VALID[0] && !PIX_DE[0] |-> PIX_RGB[23:0] == 24'h00_0000;
	endproperty
	a_blank: assert property (p_blank) else $error("blanking word not black");
endmodule
bind vtp_top vtp_monitor #(.PORTS(PORTS)) vtp_monitor_inst (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_RGB(PIX_RGB), .PIX_DE(PIX_DE));
`default_nettype wire

// ---- verif/vtp_sink.sv ----
// pixel sink standing in for the serial-link video path of one port
`default_nettype none
module vtp_sink (
	// clock and flow control
	input wire logic clk,
	input wire logic stall,
	// pixel stream
	input wire logic valid,
	output logic ready,
	input wire logic [23:0] rgb,
	input wire logic de,
	// what was received
	output int words,
	output int lines,
	output logic [23:0] px [24]
);
	timeunit 1ns;
	timeprecision 1ps;
	int run = 0;
	// ready drops at once on stall, so the generator sees a sink as slow as a real link
	assign ready = !stall;
	initial begin
		words = 0;
		lines = 0;
	end
	// rebuild the active run of each line from handshaken words
	always @(posedge clk) begin
		if (valid && ready) begin
			words <= words + 1;
			if (de) begin
				if (run < 24) px[run] <= rgb;
				run <= run + 1;
			end else if (run != 0) begin
				lines <= lines + 1;
				run <= 0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/vtp_top_tb_top.sv ----
// self-checking bench of the test-pattern block
`include "vtp_defs.svh"
`default_nettype none
module vtp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, err, vclk = 0, vde = 0, run_v = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic vhs = 0;
	logic [1:0] valid, ready, de, hs, vs, stall = 2'b00;
	logic [47:0] rgb;
	logic [23:0] px [2][24];
	int words [2], lines [2], mismatches = 0, checks = 0, cyc = 0, vcnt = 0;
	// small frame: 30x5 total, 24x2 active, custom colour ff/03/81, frame time 1, divider 0
	logic [7:0] tim [18] = '{8'h1E, 8'h00, 8'h05, 8'h00, 8'h18, 8'h00, 8'h02, 8'h00, 8'h01, 8'h01, 8'h02, 8'h01,
		8'h00, 8'h01, 8'hFF, 8'h03, 8'h81, 8'h00};
	initial begin
		forever #20 clk = ~clk;
	end
	vtp_top vtp_top_inst (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.VID_PCLK(vclk), .VID_DE(vde), .VID_HS(vhs), .VID_VS(1'b0), .PIX_VALID(valid), .PIX_READY(ready),
		.PIX_RGB(rgb), .PIX_DE(de), .PIX_HS(hs), .PIX_VS(vs));
	for (genvar p = 0; p < 2; p++) begin : g_sink
		vtp_sink vtp_sink_inst (.clk(clk), .stall(stall[p]), .valid(valid[p]), .ready(ready[p]),
			.rgb(rgb[p*24+:24]), .de(de[p]), .words(words[p]), .lines(lines[p]), .px(px[p]));
	end
	// timeout, plus external video: pixel level held 3 cycles so the 3-flop sync sees it; stands still when off
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (run_v) vcnt <= vcnt + 1;
		vclk <= run_v && (vcnt % 6 >= 3);
		vde <= vcnt % 96 >= 48;
		vhs <= vcnt % 96 < 12; // two pixel clocks of sync per external line
		if (cyc == 40000) begin
			mismatches++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one apb transfer, held until ready is sampled high
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 8'h00);
		check(rd, exp);
	endtask
	task automatic iw(input logic [4:0] a, input logic [7:0] d);
		apb(1'b1, `VTP_IDX_IA, {3'b000, a}); // address always first
		apb(1'b1, `VTP_IDX_ID, d);
	endtask
	task automatic pc(input int i, input logic [23:0] exp);
		check({8'h00, px[0][i]}, {8'h00, exp});
	endtask
	task automatic line(input int n);
		int l0;
		l0 = lines[0];
		while (lines[0] < l0 + n) @(posedge clk);
	endtask
	// three lines flush words already queued under the old setting
	task automatic shows(input logic [7:0] cfg, input logic [7:0] ctl);
		apb(1'b1, `VTP_IDX_CFG, cfg);
		apb(1'b1, `VTP_IDX_CTL, ctl);
		line(3);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rc(`VTP_IDX_CTL, 32'h0000_0010);
		rc(`VTP_IDX_CFG, 32'h0000_0000);
		rc(`VTP_IDX_IA, 32'h0000_0000);
		for (int b = 0; b < 7; b++) begin
			apb(1'b1, `VTP_IDX_CFG, 8'h01 << b);
			rc(`VTP_IDX_CFG, 32'h0000_0001 << b);
		end
		pstrb <= 4'hE;
		apb(1'b1, `VTP_IDX_IA, 8'hA5);
		pstrb <= 4'hF;
		rc(`VTP_IDX_IA, 32'h0000_0000);
		rc(10'h3FF, 32'h0000_0000);
		check({31'h0000_0000, err}, 32'h0000_0001);
		$display("t_regs done");
	endtask
	task automatic t_ind();
		for (int a = 0; a < 32; a += 9) begin
			iw(a[4:0], 8'hC3 ^ a[7:0]);
		end
		for (int a = 0; a < 32; a += 9) begin
			apb(1'b1, `VTP_IDX_IA, a[7:0]);
			rc(`VTP_IDX_ID, {24'h00_0000, 8'hC3 ^ a[7:0]});
		end
		apb(1'b1, `VTP_IDX_IA, 8'h20);
		apb(1'b1, `VTP_IDX_ID, 8'h77);
		rc(`VTP_IDX_ID, 32'h0000_0000);
		rc(`VTP_IDX_IA, 32'h0000_0020);
		apb(1'b1, `VTP_IDX_IA, 8'h00);
		rc(`VTP_IDX_ID, 32'h0000_00C3);
		$display("t_ind done");
	endtask
	task automatic t_ports();
		apb(1'b1, `VTP_IDX_PSEL, 8'h01);
		apb(1'b1, `VTP_IDX_CFG, 8'h55);
		rc(`VTP_IDX_CFG, 32'h0000_0055);
		apb(1'b1, `VTP_IDX_CFG, 8'h00);
		apb(1'b1, `VTP_IDX_PSEL, 8'h00);
		rc(`VTP_IDX_CFG, 32'h0000_0040);
		$display("t_ports done");
	endtask
	task automatic t_colour();
		int hn = 0, vn = 0;
		for (int i = 0; i < 18; i++) begin
			iw(i[4:0], tim[i]);
		end
		shows(8'h04, 8'h11);
		pc(3, 24'hFF_FFFF);
		// one pixel per cycle with an always-ready sink, so 150 edges hold exactly one frame
		for (int c = 0; c < 150; c++) begin
			@(posedge clk);
			hn += valid[0] && hs[0];
			vn += valid[0] && vs[0];
		end
		check(hn, 32'h0000_0005);
		check(vn, 32'h0000_001E);
		shows(8'h06, 8'h11);
		pc(3, 24'h00_0000);
		shows(8'h14, 8'hE1);
		pc(5, 24'hFC_0080);
		shows(8'h04, 8'h61);
		pc(23, 24'hF5_F5F5);
		shows(8'h14, 8'h61);
		pc(23, 24'hF4_F4F4);
		shows(8'h04, 8'h01);
		pc(1, px[0][0] ^ 24'hFF_FFFF);
		shows(8'h44, 8'h01);
		pc(7, px[0][0]);
		pc(8, px[0][0] ^ 24'hFF_FFFF);
		shows(8'h24, 8'h01);
		pc(1, px[0][0] ^ 24'hFF_0381);
		shows(8'h04, 8'hF1);
		pc(0, 24'h00_0000);
		pc(1, 24'hFF_FFFF);
		shows(8'h44, 8'hF1);
		pc(7, 24'h00_0000);
		pc(8, 24'hFF_FFFF);
		check(words[1], 32'h0000_0000);
		$display("t_colour done");
	endtask
	task automatic t_scroll();
		logic [3:0] s1;
		shows(8'h05, 8'h21);
		apb(1'b0, `VTP_IDX_STAT, 8'h00);
		s1 = rd[7:4];
		repeat (400) @(posedge clk);
		apb(1'b0, `VTP_IDX_STAT, 8'h00);
		// divider 0 ticks every cycle: a 150-cycle frame, so 403 cycles hold two or three frame ends
		check({31'h0000_0000, rd[7:4] - s1 inside {4'h2, 4'h3}}, 32'h0000_0001);
		apb(1'b1, `VTP_IDX_CFG, 8'h04);
		repeat (700) @(posedge clk);
		rc(`VTP_IDX_STAT, 32'h0000_0020);
		$display("t_scroll done");
	endtask
	task automatic t_flow();
		int w, h = 0;
		apb(1'b1, `VTP_IDX_CTL, 8'h11);
		stall <= 2'b01;
		repeat (100) @(posedge clk);
		check({31'h0000_0000, valid[0]}, 32'h0000_0001);
		stall <= 2'b00;
		apb(1'b1, `VTP_IDX_CFG, 8'h0C);
		repeat (100) @(posedge clk);
		w = words[0];
		repeat (200) @(posedge clk);
		check(words[0], w);
		run_v <= 1'b1;
		repeat (300) @(posedge clk);
		check({31'h0000_0000, words[0] > w}, 32'h0000_0001);
		// source bit clear under external timing: the divider must not pace pixels
		apb(1'b1, `VTP_IDX_CFG, 8'h00);
		line(3);
		pc(7, 24'hFF_FFFF);
		w = words[0];
		for (int c = 0; c < 96; c++) begin
			@(posedge clk);
			h += valid[0] && hs[0];
		end
		check(words[0] - w, 32'h0000_0010);
		check(h, 32'h0000_0002);
		stall <= 2'b01;
		repeat (300) @(posedge clk);
		stall <= 2'b00;
		repeat (50) @(posedge clk);
		rc(`VTP_IDX_STAT, 32'h0000_0011);
		apb(1'b1, `VTP_IDX_STAT, 8'h01);
		rc(`VTP_IDX_STAT, 32'h0000_0010);
		apb(1'b1, `VTP_IDX_CTL, 8'h10);
		repeat (100) @(posedge clk);
		w = words[0];
		repeat (300) @(posedge clk);
		check(words[0], w);
		run_v <= 1'b0;
		$display("t_flow done");
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_ind();
		t_ports();
		t_colour();
		t_scroll();
		t_flow();
		summarize();
	end
endmodule
`default_nettype wire
